// file: rtl/cep_defines.vh
/*
  constants of the core event priority controller: ranks, widths, modes
  and timing counts. assumes a 250 MHz core clock.
*/
`ifndef CEP_DEFINES_VH
`define CEP_DEFINES_VH

`define CEP_NUM_EVT      16
`define CEP_RANK_W       4
`define CEP_RANK_EMU     4'h0
`define CEP_RANK_RST     4'h1
`define CEP_RANK_NMI     4'h2
`define CEP_RANK_EXC     4'h3
`define CEP_RANK_RSVD    4'h4
`define CEP_RANK_HWERR   4'h5
`define CEP_RANK_TMR     4'h6
`define CEP_RANK_GEN_LO  4'h7
`define CEP_NUM_GEN      9
`define CEP_RSVD_MASK    16'h0010
`define CEP_ENABLE_RST   16'h001f
`define CEP_MODE_USER    2'h0
`define CEP_MODE_SUPV    2'h1
`define CEP_MODE_EMUL    2'h2
`define CEP_EDGE_CYCLES  2

`endif

// file: rtl/cep_edge_latch.v
/*
  rising edge detector for one event input, with a two flop synchroniser.
  assumes the input may come from any domain; detection takes three cycles.
*/
`timescale 1ns/10ps
module cep_edge_latch (
  // clock and reset
  input  wire clk,
  input  wire sys_rst,
  // event input
  input  wire eventIn,
  // one cycle pulse on a detected rising edge
  output reg  risePulse
);
  reg syncA_reg;
  reg syncB_reg;
  reg prev_reg;

  always @(posedge clk) begin
    if (sys_rst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      prev_reg  <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      syncA_reg <= eventIn;
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
      risePulse <= syncB_reg & ~prev_reg;
    end
  end
endmodule // cep_edge_latch

// file: rtl/cep_core_event_stage.v
/*
  core event stage: latches events, masks them, tracks nesting in the
  active register and dispatches the highest ranked one to the sequencer.
  assumes the sequencer answers each dispatch with an entry acknowledge
  and a resume address, and signals return from event with its rank.
*/
`timescale 1ns/10ps
`include "cep_defines.vh"

module cep_core_event_stage (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // event sources
  input  wire        emuReq,
  input  wire        rstReq,
  input  wire        wdogExpire,
  input  wire        nmiPin,
  input  wire        swNmi,
  input  wire        excMisalign,
  input  wire        excUndefOp,
  input  wire        hwErrIn,
  input  wire        coreTimerIn,
  input  wire [8:0]  generalLevelIn,
  input  wire [8:0]  swIntRaise,
  // sequencer handshake
  input  wire        entryAck,
  input  wire [31:0] resumePc,
  input  wire        returnValid,
  input  wire [3:0]  returnRank,
  // software access to latch and enable
  input  wire        accessReq,
  input  wire        enableWrite,
  input  wire [15:0] enableWData,
  input  wire        latchWrite,
  input  wire [15:0] latchWData,
  // outputs
  output reg         dispatchValid,
  output reg  [3:0]  dispatchRank,
  output reg  [15:0] eventLatch,
  output reg  [15:0] eventEnable,
  output reg  [15:0] eventActive,
  output reg  [1:0]  procMode,
  output reg         coreResetOut,
  output reg         accessDenied,
  output reg  [31:0] retEmu,
  output reg  [31:0] retNmi,
  output reg  [31:0] retExc,
  output reg  [31:0] retInt
);
  wire [8:0]  genRise;
  reg  [15:0] riseVec;
  reg  [15:0] levelReg;
  reg  [15:0] levelPrev;
  reg  [15:0] latch_next;
  reg  [15:0] active_next;
  reg  [15:0] candVec;
  reg  [3:0]  pickRank;
  reg         pickValid;
  reg  [1:0]  mode_next;
  reg  [4:0]  activeLow;
  wire        privileged;
  wire        entryTaken;
  wire        stageClear;

  function [4:0] lowest_set;  // {found, rank}
    input [15:0] vec;
    integer i;
    begin
      lowest_set = 5'h00;
      for (i = 15; i >= 0; i = i - 1)
        if (vec[i])
          lowest_set = {1'b1, i[3:0]};
    end
  endfunction

  // general levels may come from another domain, so each passes a synchroniser
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : genEdge
      cep_edge_latch uEdge (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .eventIn  (generalLevelIn[g]),
        .risePulse(genRise[g])
      );
    end
  endgenerate

  // internal sources arrive on clk, so their edges are found directly
  always @(posedge clk) begin
    if (sys_rst) begin
      levelReg  <= 16'h0000;
      levelPrev <= 16'h0000;
    end else begin
      levelReg  <= {swIntRaise[8:7], 7'h00, coreTimerIn, hwErrIn, 1'b0,
                    excMisalign | excUndefOp, wdogExpire | nmiPin | swNmi,
                    rstReq, emuReq};
      levelPrev <= levelReg;
    end
  end

  always @* begin
    riseVec = (levelReg & ~levelPrev) | {genRise, 7'h00};
    // the reserved rank can never latch, whatever the inputs do
    riseVec = riseVec & ~`CEP_RSVD_MASK;
  end

  assign privileged = (procMode != `CEP_MODE_USER);
  assign entryTaken = dispatchValid && entryAck;
  // a reset class entry clears the stage as the reset input does, except levelReg, levelPrev and the edge latches, and it sets coreResetOut
  assign stageClear = sys_rst || (entryTaken && dispatchRank == `CEP_RANK_RST);

  always @* begin
    // lowest active rank blocks itself and all below
    // ranks zero to two ignore the enable bits: they are nonmaskable
    candVec = eventLatch & (eventEnable | 16'h0007);
    {pickValid, pickRank} = lowest_set(candVec & ~`CEP_RSVD_MASK);
    activeLow = lowest_set(eventActive);
    if (pickValid && activeLow[4] && pickRank >= activeLow[3:0])
      pickValid = 1'b0;
  end

  // a latch write may only touch bits whose enable is clear
  always @* begin
    latch_next  = eventLatch;
    active_next = eventActive;
    mode_next   = procMode;
    if (latchWrite && privileged)
      latch_next = (latchWData & ~eventEnable) | (eventLatch & eventEnable);
    if (returnValid) begin
      active_next[returnRank] = 1'b0;
      if (returnRank == `CEP_RANK_EMU)
        mode_next = `CEP_MODE_SUPV;
      // leaving the last handler drops back to user mode
      else if ((eventActive & ~(16'h0001 << returnRank)) == 16'h0000)
        mode_next = `CEP_MODE_USER;
    end
    if (entryTaken) begin
      active_next[dispatchRank] = 1'b1;
      latch_next[dispatchRank]  = 1'b0;
      if (dispatchRank == `CEP_RANK_EMU)
        mode_next = `CEP_MODE_EMUL;
      else if (mode_next == `CEP_MODE_USER)
        mode_next = `CEP_MODE_SUPV;
    end
    // set wins: a fresh edge survives the clear of its own entry
    latch_next = latch_next | riseVec;
    latch_next = latch_next & ~`CEP_RSVD_MASK;
  end

  always @(posedge clk) begin
    if (stageClear) begin
      eventLatch    <= 16'h0000;
      eventActive   <= 16'h0000;
      procMode      <= `CEP_MODE_SUPV;
      dispatchValid <= 1'b0;
      dispatchRank  <= 4'h0;
      coreResetOut  <= ~sys_rst;
    end else begin
      eventLatch    <= latch_next;
      eventActive   <= active_next;
      procMode      <= mode_next;
      coreResetOut  <= 1'b0;
      // the offer drops on acceptance so one edge makes one entry
      // registering it costs a cycle but keeps the output glitch free
      dispatchValid <= pickValid && !entryTaken;
      dispatchRank  <= pickRank;
    end
  end

  // software access runs apart so a refused write still reports itself
  always @(posedge clk) begin
    if (stageClear) begin
      eventEnable  <= `CEP_ENABLE_RST;
      accessDenied <= 1'b0;
    end else begin
      accessDenied <= accessReq && !privileged;
      if (enableWrite && privileged)
        eventEnable <= enableWData & ~`CEP_RSVD_MASK;
    end
  end

  // one return address per class; ranks five and up share one register
  always @(posedge clk) begin
    if (stageClear) begin
      retEmu <= 32'h00000000;
      retNmi <= 32'h00000000;
      retExc <= 32'h00000000;
      retInt <= 32'h00000000;
    end else if (entryTaken) begin
      case (dispatchRank)
        `CEP_RANK_EMU: retEmu <= resumePc;
        `CEP_RANK_NMI: retNmi <= resumePc;
        `CEP_RANK_EXC: retExc <= resumePc;
        default:       retInt <= resumePc;
      endcase
    end
  end
endmodule // cep_core_event_stage

// file: testbench/cep_core_event_stage_assertions.sv
/* checks on the core event stage ports; bound to the core event stage after the module */
`timescale 1ns/10ps
`include "cep_defines.vh"
module cep_core_event_stage_assertions (
  input wire clk, sys_rst, nmiPin, entryAck, dispatchValid,
  input wire [8:0] generalLevelIn,
  input wire [3:0] dispatchRank,
  input wire [15:0] eventLatch, eventEnable, eventActive,
  input wire [1:0] procMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // rank 1 entry resets the stage, so it is left out here
  sequence taken; entryAck && dispatchValid && dispatchRank != 4'h1; endsequence
  chk_ack_drops_valid: assert property (taken |=> !dispatchValid) else $error("valid held");
  chk_ack_sets_active: assert property (taken |=> eventActive[$past(dispatchRank)])
    else $error("no active bit");
  chk_rsvd_never_used: assert property (!eventActive[4] && !(dispatchValid && dispatchRank == 4'h4))
    else $error("rank 4 used");
  chk_above_all_active: assert property (dispatchValid |->
    (eventActive & ~(16'hffff << (dispatchRank + 5'h1))) == 16'h0) else $error("not above active");
  chk_dispatch_enabled: assert property (dispatchValid |-> eventLatch[dispatchRank] &&
    (eventEnable[dispatchRank] || dispatchRank < 4'h3)) else $error("masked dispatch");
  chk_nmi_edge_latch: assert property ($rose(nmiPin) |-> ##[2:3] eventLatch[2]) else $error("no latch");
  chk_gen_min_delay: assert property ($rose(generalLevelIn[0]) && !eventActive[7] |->
    !eventActive[7] [*3]) else $error("too fast");
  chk_reset_values: assert property ($fell(sys_rst) |-> eventEnable == `CEP_ENABLE_RST &&
    eventActive == 16'h0 && procMode == `CEP_MODE_SUPV) else $error("bad reset state");
endmodule // cep_core_event_stage_assertions
bind cep_core_event_stage cep_core_event_stage_assertions chk (.clk(clk), .sys_rst(sys_rst),
  .nmiPin(nmiPin), .entryAck(entryAck), .dispatchValid(dispatchValid),
  .generalLevelIn(generalLevelIn), .dispatchRank(dispatchRank), .eventLatch(eventLatch),
  .eventEnable(eventEnable), .eventActive(eventActive), .procMode(procMode));

// file: testbench/cep_map_stage_model.sv
/* system mapping stage model: peripheral requests onto general levels;
   assumes the core clock */
`timescale 1ns/10ps
module cep_map_stage_model (
  input wire clk,
  input wire [6:0] srcReq,
  output logic [8:0] generalLevel = 9'h0
);
  // the two highest levels (bits 8 and 7) stay free for software handlers
  always @(posedge clk) generalLevel <= {2'h0, srcReq};
endmodule // cep_map_stage_model

// file: testbench/tb_cep_core_event_stage.sv
/* testbench of the core event stage; acts as the sequencer, with
   peripherals behind the mapping stage model */
`timescale 1ns/10ps
module tb_cep_core_event_stage;
  logic clk = 0, sys_rst = 1, entryAck = 0, returnValid = 0, accessReq = 0, enableWrite = 0;
  logic [9:0] ev = 0;
  logic [3:0] returnRank = 0;
  logic [31:0] resumePc = 0;
  logic [15:0] enableWData = 0;
  logic dispatchValid, accessDenied, coreResetOut;
  logic [3:0] dispatchRank;
  logic [1:0] procMode;
  logic [8:0] genLvl;
  logic [15:0] eventLatch, eventEnable, eventActive;
  logic [31:0] retEmu, retNmi, retExc, retInt;
  int n_errors = 0, n_compared = 0;
  logic [3:0] rk [10] = '{0, 1, 2, 2, 2, 3, 3, 5, 6, 7};
  cep_map_stage_model map (.clk(clk), .srcReq({6'h0, ev[9]}), .generalLevel(genLvl));
  cep_core_event_stage dut (.clk(clk), .sys_rst(sys_rst), .emuReq(ev[0]), .rstReq(ev[1]),
    .wdogExpire(ev[2]), .nmiPin(ev[3]), .swNmi(ev[4]), .excMisalign(ev[5]), .excUndefOp(ev[6]),
    .hwErrIn(ev[7]), .coreTimerIn(ev[8]), .generalLevelIn(genLvl), .swIntRaise(9'h0),
    .entryAck(entryAck), .resumePc(resumePc), .returnValid(returnValid), .returnRank(returnRank),
    .accessReq(accessReq), .enableWrite(enableWrite), .enableWData(enableWData),
    .latchWrite(1'b0), .latchWData(16'h0), .dispatchValid(dispatchValid),
    .dispatchRank(dispatchRank), .eventLatch(eventLatch), .eventEnable(eventEnable),
    .eventActive(eventActive), .procMode(procMode), .coreResetOut(coreResetOut),
    .accessDenied(accessDenied),
    .retEmu(retEmu), .retNmi(retNmi), .retExc(retExc), .retInt(retInt));
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic serve(input int i);
    int n = 0;
    ev[i] = 1;
    while (dispatchValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(dispatchRank, rk[i]);
    resumePc = 32'h100 + i;
    entryAck = 1;
    @(negedge clk);
    entryAck = 0;
    chk(eventActive[rk[i]], 1);
    chk(rk[i] == 0 ? retEmu : rk[i] < 3 ? retNmi : rk[i] == 3 ? retExc : retInt, resumePc);
  endtask
  task automatic done(input int i);
    ev[i] = 0;
    returnRank = rk[i];
    returnValid = 1;
    @(negedge clk);
    returnValid = 0;
    chk(eventActive[rk[i]], 0);
    @(negedge clk);
  endtask
  task automatic t_classes();
    for (int i = 2; i < 7; i++) begin
      serve(i);
      done(i);
    end
    chk(procMode, 2'h0);
    enableWData = 16'hffef;
    enableWrite = 1;
    accessReq = 1;
    @(negedge clk);
    enableWrite = 0;
    accessReq = 0;
    chk(accessDenied, 1);
    chk(eventEnable, 16'h001f);
  endtask
  task automatic t_core_reset();
    int n = 0;
    ev[1] = 1;
    while (dispatchValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(dispatchRank, 4'h1);
    entryAck = 1;
    @(negedge clk);
    entryAck = 0;
    ev[1] = 0;
    chk(coreResetOut, 1);
    chk(eventEnable, 16'h001f);
    chk(procMode, 2'h1);
    @(negedge clk);
    chk(coreResetOut, 0);
  endtask
  task automatic t_mask_nest();
    ev[8] = 1;
    repeat (8) @(negedge clk);
    chk(dispatchValid, 0);
    chk(eventLatch[6], 1);
    enableWData = 16'hffef;
    enableWrite = 1;
    accessReq = 1;
    @(negedge clk);
    enableWrite = 0;
    accessReq = 0;
    chk(eventEnable, 16'hffef);
    serve(8);
    serve(3);
    chk(eventActive, 16'h0044);
    ev[9] = 1;
    repeat (8) @(negedge clk);
    chk(dispatchValid, 0);
    done(3);
    done(8);
    serve(9);
    done(9);
  endtask
  task automatic t_emul();
    serve(0);
    chk(procMode, 2'h2);
    done(0);
    chk(procMode, 2'h1);
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #2 clk = ~clk;
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    chk(eventEnable, 16'h001f);
    chk(procMode, 2'h1);
    t_classes();
    t_emul();
    t_mask_nest();
    t_core_reset();
    complete_run();
  end
  // a hang costs far more than the hundred or so cycles the tests need
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule // tb_cep_core_event_stage
